// ---- core/rtco_pkg.sv ----
// Package of register map, field positions and carriers for the oscillator control
package rtco_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_SNAP0 = 6'h00;
    localparam logic [5:0] IDX_CTRL = 6'h04;
    localparam logic [5:0] IDX_OSC_CONTROL = 6'h05;
    localparam logic [5:0] IDX_OSC_CONFIG = 6'h06;
    localparam logic [5:0] IDX_PIN_CONFIG = 6'h07;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h0C;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h0D;
    localparam int SNAP_BYTES = 4;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_ALARM_BIT = 2;
    localparam int CTRL_LOAD_BIT = 1;
    localparam int CTRL_SNAP_BIT = 0;
    localparam int GAIN_BIT = 7;
    localparam int CRYSTAL_MODE_SELECT_BIT = 6;
    localparam int BIAS_BIT = 5;
    localparam int VALID_BIT = 4;
    localparam int STEP_BIT = 7;
    localparam int READY_BIT = 6;
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_LOAD = 1;
    localparam int IRQ_SNAP = 2;
    localparam int IRQ_CAP = 3;
    localparam int IRQ_BITS = 4;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] OSC_CONTROL_RESET = 8'h00;
    localparam logic [3:0] CAP_TARGET_RESET = 4'h0;
    localparam logic [7:0] PIN_SHORT_CODE = 8'hE7;
    localparam logic [7:0] PIN_NORMAL_CODE = 8'h67;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
    localparam logic [3:0] CAP_ONE = 4'h1;

    // Oscillator analogue controls leaving the block
    typedef struct packed {
        logic gainControlEnable;
        logic crystalModeSelect;
        logic biasDoubleEnable;
        logic pinShort;
        logic [3:0] capSetting;
    } rtco_osc_s;

endpackage

// ---- core/rtco_osc_ctrl.sv ----
// Oscillator control, counter set/snapshot and alarm flag behind Avalon-MM
`timescale 1ns/1ns
`default_nettype none

module rtco_osc_ctrl
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic lfClkPin,
    input wire logic amplitudeOkPin,
    input wire logic alarmMatch,
    output rtco_pkg::rtco_osc_s oscCtrl,
    output logic irq
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic regHit(input logic [7:0] addr,
                                    input logic [5:0] idx);
        regHit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers, three stages, change taken when 2 and 3 agree
    // ------------------------------------------------------------
    logic lfS1;
    logic lfS2;
    logic lfS3;
    logic lfLevel;
    logic ampS1;
    logic ampS2;
    logic ampS3;
    logic oscillationValid;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            lfS1 <= 1'b0;
            lfS2 <= 1'b0;
            lfS3 <= 1'b0;
            ampS1 <= 1'b0;
            ampS2 <= 1'b0;
            ampS3 <= 1'b0;
        end
        else
        begin
            lfS1 <= lfClkPin;
            lfS2 <= lfS1;
            lfS3 <= lfS2;
            ampS1 <= amplitudeOkPin;
            ampS2 <= ampS1;
            ampS3 <= ampS2;
        end
    end

    wire logic lfAgree = (lfS2 == lfS3);
    // One-cycle enable per low-frequency rising edge
    wire logic lfTick = lfAgree && lfS3 && !lfLevel;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            lfLevel <= 1'b0;
            oscillationValid <= 1'b0;
        end
        else
        begin
            if (lfAgree)
                lfLevel <= lfS3;
            if (ampS2 == ampS3)
                oscillationValid <= ampS3;
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then a single answer cycle
    // ------------------------------------------------------------
    wire logic access = (read || write) && waitrequest;
    wire logic wrDone = write && !waitrequest && byteenable[0];
    wire logic [7:0] wrByte = writedata[7:0];
    wire logic hitCtrl = regHit(address, rtco_pkg::IDX_CTRL);
    wire logic hitOscCtl = regHit(address, rtco_pkg::IDX_OSC_CONTROL);
    wire logic hitOscCfg = regHit(address, rtco_pkg::IDX_OSC_CONFIG);
    wire logic hitPin = regHit(address, rtco_pkg::IDX_PIN_CONFIG);
    wire logic hitStat = regHit(address, rtco_pkg::IDX_IRQ_STATUS);
    wire logic hitMask = regHit(address, rtco_pkg::IDX_IRQ_MASK);
    wire logic wrCtrl = wrDone && hitCtrl;

    // ------------------------------------------------------------
    // Counter, snapshot bytes and request bits
    // ------------------------------------------------------------
    logic [31:0] counter;
    logic [7:0] snapByte [rtco_pkg::SNAP_BYTES];
    logic loadReq;
    logic snapReq;
    logic alarmFlag;
    logic autoReset;
    logic [31:0] snapWord;
    logic [31:0] next_counter;

    // Snapshot byte 0 holds the least significant byte
    genvar gi;
    generate
        for (gi = 0; gi < rtco_pkg::SNAP_BYTES; gi = gi + 1)
        begin : g_snap
            wire logic hitSnap = regHit(address,
                6'(rtco_pkg::IDX_SNAP0 + 6'(gi)));
            assign snapWord[gi*8 +: 8] = snapByte[gi];
            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                    snapByte[gi] <= 8'h00;
                else if (lfTick && snapReq)
                    snapByte[gi] <= next_counter[gi*8 +: 8];
                else if (wrDone && hitSnap)
                    snapByte[gi] <= wrByte;
            end
        end
    endgenerate

    // Both requests are served on the same low-frequency edge; a load
    // goes first so a paired snapshot sees the freshly loaded value.
    always_comb
    begin
        next_counter = counter;
        if (lfTick)
        begin
            if (loadReq)
                next_counter = snapWord;
            else if (alarmFlag && autoReset)
                next_counter = rtco_pkg::COUNT_RESET;
            else
                next_counter = counter + rtco_pkg::COUNT_ONE;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            counter <= rtco_pkg::COUNT_RESET;
        else
            counter <= next_counter;
    end

    // Requests finish on the next low-frequency edge; a write of 0 has
    // no effect so software cannot abort an operation half done.
    // A request written on a tick cycle wins, else it would be lost.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            loadReq <= 1'b0;
            snapReq <= 1'b0;
            autoReset <= 1'b0;
        end
        else
        begin
            if (wrCtrl && wrByte[rtco_pkg::CTRL_LOAD_BIT])
                loadReq <= 1'b1;
            else if (lfTick)
                loadReq <= 1'b0;
            if (wrCtrl && wrByte[rtco_pkg::CTRL_SNAP_BIT])
                snapReq <= 1'b1;
            else if (lfTick)
                snapReq <= 1'b0;
            if (wrCtrl)
                autoReset <= wrByte[rtco_pkg::CTRL_ALARM_BIT];
        end
    end

    // Alarm flag lives at most one low-frequency cycle; a new match wins
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            alarmFlag <= 1'b0;
        else if (alarmMatch)
            alarmFlag <= 1'b1;
        else if (lfTick)
            alarmFlag <= 1'b0;
    end

    // ------------------------------------------------------------
    // Oscillator control, configuration and pin register
    // ------------------------------------------------------------
    logic gainEn;
    logic crystal_mode_select;
    logic biasDbl;
    logic stepEn;
    logic [3:0] capTarget;
    logic [3:0] capNow;
    logic [7:0] pinCode;
    wire logic capReady = (capNow == capTarget);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            gainEn <= rtco_pkg::OSC_CONTROL_RESET[rtco_pkg::GAIN_BIT];
            crystal_mode_select <= rtco_pkg::OSC_CONTROL_RESET[rtco_pkg::CRYSTAL_MODE_SELECT_BIT];
            biasDbl <= rtco_pkg::OSC_CONTROL_RESET[rtco_pkg::BIAS_BIT];
            stepEn <= 1'b0;
            capTarget <= rtco_pkg::CAP_TARGET_RESET;
            pinCode <= rtco_pkg::PIN_NORMAL_CODE;
        end
        else
        begin
            if (wrDone && hitOscCtl)
            begin
                gainEn <= wrByte[rtco_pkg::GAIN_BIT];
                crystal_mode_select <= wrByte[rtco_pkg::CRYSTAL_MODE_SELECT_BIT];
                biasDbl <= wrByte[rtco_pkg::BIAS_BIT];
            end
            if (wrDone && hitOscCfg)
            begin
                stepEn <= wrByte[rtco_pkg::STEP_BIT];
                capTarget <= wrByte[3:0];
            end
            if (wrDone && hitPin)
                pinCode <= wrByte;
        end
    end

    // Stepping moves one code per low-frequency cycle to avoid a sudden
    // load jump that could stall the oscillator.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            capNow <= rtco_pkg::CAP_TARGET_RESET;
        else if (!stepEn)
            capNow <= capTarget;
        else if (lfTick && !capReady)
        begin
            if (capNow < capTarget)
                capNow <= capNow + rtco_pkg::CAP_ONE;
            else
                capNow <= capNow - rtco_pkg::CAP_ONE;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status (write one to clear) and mask
    // ------------------------------------------------------------
    logic [rtco_pkg::IRQ_BITS-1:0] irqStatus;
    logic [rtco_pkg::IRQ_BITS-1:0] irqMask;
    logic capReadyQ;
    wire logic [rtco_pkg::IRQ_BITS-1:0] irqEvent;
    assign irqEvent[rtco_pkg::IRQ_ALARM] = alarmMatch;
    assign irqEvent[rtco_pkg::IRQ_LOAD] = lfTick && loadReq;
    assign irqEvent[rtco_pkg::IRQ_SNAP] = lfTick && snapReq;
    assign irqEvent[rtco_pkg::IRQ_CAP] = capReady && !capReadyQ;
    wire logic [rtco_pkg::IRQ_BITS-1:0] clrBits =
        (wrDone && hitStat) ? wrByte[rtco_pkg::IRQ_BITS-1:0] : '0;
    wire logic [rtco_pkg::IRQ_BITS-1:0] next_irqStatus =
        (irqStatus & ~clrBits) | irqEvent;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            irqStatus <= '0;
            irqMask <= '0;
            capReadyQ <= 1'b1;
            irq <= 1'b0;
        end
        else
        begin
            irqStatus <= next_irqStatus;
            capReadyQ <= capReady;
            if (wrDone && hitMask)
                irqMask <= wrByte[rtco_pkg::IRQ_BITS-1:0];
            irq <= |(next_irqStatus & irqMask);
        end
    end

    // ------------------------------------------------------------
    // Read multiplexer; unmapped and write-only locations read zero
    // ------------------------------------------------------------
    wire logic [7:0] ctrlRd = {5'b00000, alarmFlag, loadReq, snapReq};
    wire logic [7:0] oscCtlRd = {gainEn, crystal_mode_select, biasDbl, oscillationValid,
                                 4'b0000};
    wire logic [7:0] oscCfgRd = {stepEn, capReady, 2'b00,
                                 capTarget};
    logic [7:0] rdByte;
    always_comb
    begin
        rdByte = 8'h00;
        if (address[1:0] == 2'b00)
        begin
            case (address[7:2])
                6'h00, 6'h01, 6'h02, 6'h03:
                    rdByte = snapByte[address[3:2]];
                rtco_pkg::IDX_CTRL: rdByte = ctrlRd;
                rtco_pkg::IDX_OSC_CONTROL: rdByte = oscCtlRd;
                rtco_pkg::IDX_OSC_CONFIG: rdByte = oscCfgRd;
                rtco_pkg::IDX_IRQ_STATUS: rdByte = 8'(irqStatus);
                rtco_pkg::IDX_IRQ_MASK: rdByte = 8'(irqMask);
                default: rdByte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            waitrequest <= !access;
            if (access && read)
                readdata <= {24'h00_0000, rdByte};
        end
    end

    // ------------------------------------------------------------
    // Analogue controls, all from flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            oscCtrl <= '{1'b0, 1'b0, 1'b0, 1'b0,
                         rtco_pkg::CAP_TARGET_RESET};
        else
        begin
            oscCtrl.gainControlEnable <= gainEn;
            oscCtrl.crystalModeSelect <= crystal_mode_select;
            oscCtrl.biasDoubleEnable <= biasDbl;
            oscCtrl.pinShort <= (pinCode == rtco_pkg::PIN_SHORT_CODE);
            oscCtrl.capSetting <= capNow;
        end
    end

endmodule

`default_nettype wire

// ---- verif/rtco_osc_ctrl_props.sv ----
// Port-level assertions for the oscillator control block
`timescale 1ns/1ns
`default_nettype none

module rtco_osc_ctrl_props
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic lfClkPin,
    input wire logic amplitudeOkPin,
    input wire logic alarmMatch,
    input wire rtco_pkg::rtco_osc_s oscCtrl,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Access decode and assertions
    // ------------------------------------------------------------
    localparam logic [7:0] aOsc = {rtco_pkg::IDX_OSC_CONTROL, 2'b00};
    localparam logic [7:0] aCfg = {rtco_pkg::IDX_OSC_CONFIG, 2'b00};
    localparam logic [7:0] aPin = {rtco_pkg::IDX_PIN_CONFIG, 2'b00};
    wire logic wrDone = write && !waitrequest && byteenable[0];
    wire logic rdDone = read && !waitrequest;
    wire logic oscWr = wrDone && address == aOsc;
    wire logic pinWr = wrDone && address == aPin;
    wire logic pinShortWr = writedata[7:0] == rtco_pkg::PIN_SHORT_CODE;
    wire logic wdGain = writedata[rtco_pkg::GAIN_BIT];
    wire logic wdBias = writedata[rtco_pkg::BIAS_BIT];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("waitrequest late");
    wait_one_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    rdata_upper_a: assert property (rdDone |-> readdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    osc_unused_a: assert property (rdDone && address == aOsc |-> readdata[3:0] == 4'h0)
        else $error("unused control bits set");
    cfg_unused_a: assert property (rdDone && address == aCfg |-> readdata[5:4] == 2'b00)
        else $error("unused config bits set");
    pin_read_a: assert property (rdDone && address == aPin |-> readdata == 32'h0000_0000)
        else $error("pin register readable");
    pin_short_a: assert property ($changed(oscCtrl.pinShort) |-> $past(pinWr, 2) && oscCtrl.pinShort == $past(pinShortWr, 2))
        else $error("pin short mismatch");
    gain_follow_a: assert property ($past(oscWr, 2) |-> oscCtrl.gainControlEnable == $past(wdGain, 2))
        else $error("gain control mismatch");
    mode_hold_a: assert property ($changed(oscCtrl.crystalModeSelect) |-> $past(oscWr, 2))
        else $error("mode changed without write");
    bias_follow_a: assert property ($past(oscWr, 2) |-> oscCtrl.biasDoubleEnable == $past(wdBias, 2))
        else $error("bias double mismatch");
endmodule

bind rtco_osc_ctrl rtco_osc_ctrl_props u_rtco_osc_ctrl_props
(
    .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .lfClkPin(lfClkPin),
    .amplitudeOkPin(amplitudeOkPin), .alarmMatch(alarmMatch),
    .oscCtrl(oscCtrl), .irq(irq)
);

`default_nettype wire

// ---- verif/rtco_osc_model.sv ----
// Behavioural low-frequency oscillator feeding the clock and amplitude pins
`timescale 1ns/1ns
`default_nettype none

module rtco_osc_model
#(
    parameter int HALF_PERIOD = 8,
    parameter int START_DELAY = 5
)
(
    input wire logic ref_clk,
    input wire logic ampEnable,
    output var logic lfClkPin,
    output var logic amplitudeOkPin
);
    // ------------------------------------------------------------
    // Oscillator
    // ------------------------------------------------------------
    // Scaled far faster than a real crystal to keep runs short; runs free
    int halfCount = 0;
    int startCount = 0;
    initial
    begin
        lfClkPin = 1'b0;
        amplitudeOkPin = 1'b0;
    end
    always @(posedge ref_clk)
    begin
        halfCount <= (halfCount == HALF_PERIOD - 1) ? 0 : halfCount + 1;
        if (halfCount == HALF_PERIOD - 1)
            lfClkPin <= ~lfClkPin;
        startCount <= ampEnable ? startCount + 1 : 0;
        // Amplitude builds up only some cycles after start
        amplitudeOkPin <= ampEnable && startCount >= START_DELAY;
    end
endmodule

`default_nettype wire

// ---- verif/rtco_osc_ctrl_bench.sv ----
// Register-level self-checking tests of the oscillator control block
`timescale 1ns/1ns
`default_nettype none

module rtco_osc_ctrl_bench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    logic lfClkPin;
    logic amplitudeOkPin;
    logic alarmMatch = 1'b0;
    logic ampEnable = 1'b0;
    logic irq;
    rtco_pkg::rtco_osc_s oscCtrl;
    logic [7:0] rd;
    logic [7:0] oscVal [4] = '{8'hFF, 8'h40, 8'h20, 8'h80};
    logic [31:0] snapV = 32'h4433_2211;
    time t0;
    int fails = 0;
    int checks = 0;
    localparam logic [7:0] aCtrl = {rtco_pkg::IDX_CTRL, 2'b00};
    localparam logic [7:0] aOsc = {rtco_pkg::IDX_OSC_CONTROL, 2'b00};
    localparam logic [7:0] aCfg = {rtco_pkg::IDX_OSC_CONFIG, 2'b00};
    localparam logic [7:0] aPin = {rtco_pkg::IDX_PIN_CONFIG, 2'b00};
    localparam logic [7:0] aStat = {rtco_pkg::IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] aMask = {rtco_pkg::IDX_IRQ_MASK, 2'b00};

    rtco_osc_ctrl u_rtco_osc_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .lfClkPin(lfClkPin), .amplitudeOkPin(amplitudeOkPin),
        .alarmMatch(alarmMatch), .oscCtrl(oscCtrl), .irq(irq));
    rtco_osc_model u_rtco_osc_model (.ref_clk(ref_clk),
        .ampEnable(ampEnable), .lfClkPin(lfClkPin),
        .amplitudeOkPin(amplitudeOkPin));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic waitAck();
        int k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 100);
        check8({7'h00, waitrequest}, 8'h00);
    endtask
    task automatic avWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        address <= a;
        writedata <= {24'h00_0000, d};
        write <= 1'b1;
        waitAck();
        write <= 1'b0;
    endtask
    task automatic avRead(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        address <= a;
        read <= 1'b1;
        waitAck();
        d = readdata[7:0];
        read <= 1'b0;
    endtask
    task automatic rdCheck(input logic [7:0] a, input logic [7:0] exp);
        avRead(a, rd);
        check8(rd, exp);
    endtask
    // Software may only go on once the awaited bits read as wanted
    task automatic pollBit(input logic [7:0] a, input logic [7:0] m,
                           input logic [7:0] w);
        int k = 0;
        do
        begin
            avRead(a, rd);
            k++;
        end while ((rd & m) !== w && k < 80);
        check8(rd & m, w);
    endtask
    task automatic pulseAlarm();
        @(posedge ref_clk);
        alarmMatch <= 1'b1;
        @(posedge ref_clk);
        alarmMatch <= 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        fails++;
        test_done();
    end
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdCheck(aOsc, rtco_pkg::OSC_CONTROL_RESET);
        rdCheck(aCfg, {4'h4, rtco_pkg::CAP_TARGET_RESET});
        rdCheck(aPin, 8'h00);
        check8(oscCtrl, 8'h00);
        rdCheck(8'h20, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            avWrite(aOsc, oscVal[i]);
            rdCheck(aOsc, oscVal[i] & 8'hE0);
            check8(oscCtrl, oscVal[i] & 8'hE0);
        end
        byteenable <= 4'h0;
        avWrite(aOsc, 8'h00);
        byteenable <= 4'hF;
        rdCheck(aOsc, 8'h80);
        ampEnable <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rdCheck(aOsc, 8'h90);
        ampEnable <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rdCheck(aOsc, 8'h80);
        avWrite(aPin, rtco_pkg::PIN_SHORT_CODE);
        repeat (2) @(posedge ref_clk);
        check8(oscCtrl, 8'h90);
        avWrite(aPin, rtco_pkg::PIN_NORMAL_CODE);
        repeat (2) @(posedge ref_clk);
        check8(oscCtrl, 8'h80);
        avWrite(aCfg, 8'h33);
        repeat (4) @(posedge ref_clk);
        rdCheck(aCfg, 8'h43);
        check8(oscCtrl, 8'h83);
        avWrite(aCfg, 8'h89);
        t0 = $time;
        repeat (4) @(posedge ref_clk);
        rdCheck(aCfg, 8'h89);
        pollBit(aCfg, 8'h40, 8'h40);
        check8({7'h00, ($time - t0) > 1200}, 8'h01);
        check8(oscCtrl, 8'h89);
        @(posedge lfClkPin);
        repeat (5) @(posedge ref_clk);
        pulseAlarm();
        rdCheck(aCtrl, 8'h04);
        repeat (24) @(posedge ref_clk);
        rdCheck(aCtrl, 8'h00);
        for (int i = 0; i < 4; i++)
            avWrite(8'(4 * i), snapV[8 * i +: 8]);
        avWrite(aCtrl, 8'h03);
        pollBit(aCtrl, 8'h03, 8'h00);
        for (int i = 0; i < 4; i++)
            rdCheck(8'(4 * i), snapV[8 * i +: 8]);
        avWrite(8'h00, 8'h00);
        avWrite(aCtrl, 8'h01);
        pollBit(aCtrl, 8'h01, 8'h00);
        for (int i = 1; i < 4; i++)
            rdCheck(8'(4 * i), snapV[8 * i +: 8]);
        avRead(8'h00, rd);
        check8({7'h00, rd > 8'h11}, 8'h01);
        avWrite(aCtrl, 8'h04);
        rdCheck(aCtrl, 8'h00);
        pulseAlarm();
        repeat (40) @(posedge ref_clk);
        avWrite(aCtrl, 8'h01);
        pollBit(aCtrl, 8'h01, 8'h00);
        rdCheck(8'h0C, 8'h00);
        rdCheck(aStat, 8'h0F);
        check8({7'h00, irq}, 8'h00);
        avWrite(aMask, 8'h04);
        rdCheck(aMask, 8'h04);
        check8({7'h00, irq}, 8'h01);
        avWrite(aStat, 8'h04);
        rdCheck(aStat, 8'h0B);
        check8({7'h00, irq}, 8'h00);
        test_done();
    end
endmodule

`default_nettype wire
